// >>> hw/ict_timing_map.vh
// constants for the instruction-cycle timing sequencer
// assumes inclusion by bare name from the single design file
`ifndef ICT_TIMING_MAP_VH
`define ICT_TIMING_MAP_VH
// system clocks per instruction cycle and phase counter
`define ICT_PHASES 3'd4
`define ICT_PHASE_W 2
`define ICT_PHASE_FIRST 2'h0
`define ICT_PHASE_LAST 2'h3
// instruction classes presented by the decoder
`define ICT_CLASS_W 4
`define ICT_CLASS_ORDINARY 4'h0
`define ICT_CLASS_JUMP 4'h1
`define ICT_CLASS_CALL 4'h2
`define ICT_CLASS_SUB_RETURN 4'h3
`define ICT_CLASS_INT_RETURN 4'h4
`define ICT_CLASS_TABLE_RD 4'h5
`define ICT_CLASS_SKIP 4'h6
`define ICT_CLASS_MOVE_R2A 4'h7
`define ICT_CLASS_MOVE_A2R 4'h8
`define ICT_CLASS_MOVE_IMM 4'h9
// data move form codes
`define ICT_MOVE_W 2
`define ICT_MOVE_NONE 2'h0
`define ICT_MOVE_R2A 2'h1
`define ICT_MOVE_A2R 2'h2
`define ICT_MOVE_IMM 2'h3
`endif

// >>> hw/ict_timing.v
// instruction-cycle timing: divides the system clock into instruction cycles and
// stretches each instruction to one or two of them.
// assumes the decoder holds class and flags stable while ready is low.
// Summary of operation
// - ordinary instructions finish in one instruction cycle
// - jump, call, returns and table reads take two instruction cycles
// - one instruction cycle is four system clocks
// - writing the low program counter byte acts as a jump, extra cycle
// - a taken skip costs one extra cycle, untaken skip none
// - three data move forms: register to acc, acc to register, immediate
// - fixed programmed option enables or disables one port line pull-low
`timescale 1ns/10ps
`include "ict_timing_map.vh"
module ict_timing (
    // clock and reset
    input wire core_clk_in,
    input wire rst_in,
    // decoded instruction
    input wire [`ICT_CLASS_W-1:0] instr_class_in,
    input wire writes_program_counter_low_byte_in,
    input wire skip_taken_in,
    // programmed option
    input wire pulldown_option_cfg_in,
    // timing outputs
    output reg instr_cycle_out,
    output reg [`ICT_PHASE_W-1:0] phase_out,
    output reg fetch_ready_out,
    output reg extra_cycle_out,
    output reg [`ICT_MOVE_W-1:0] data_move_instruction_out,
    output reg pulldown_option_port_line_en_out
);

localparam ST_FIRST = 2'b01;
localparam ST_SECOND = 2'b10;

reg [`ICT_PHASE_W-1:0] phase;
reg [`ICT_PHASE_W-1:0] next_phase;
reg [1:0] state;
reg [1:0] next_state;
reg next_extra;
reg next_instr_cycle;
reg next_fetch_ready;
reg [`ICT_MOVE_W-1:0] next_move;
wire cycle_end;
wire wants_two;

// class needs a second instruction cycle
function needs_two;
    input [`ICT_CLASS_W-1:0] cls;
    input lowpc_wr;
    input skip;
    begin
        case (cls)
            `ICT_CLASS_JUMP, `ICT_CLASS_CALL, `ICT_CLASS_SUB_RETURN,
            `ICT_CLASS_INT_RETURN, `ICT_CLASS_TABLE_RD: begin
                needs_two = 1'b1;
            end
            `ICT_CLASS_SKIP: begin
                needs_two = skip | lowpc_wr;
            end
            default: begin
                needs_two = lowpc_wr;
            end
        endcase
    end
endfunction

// data move form of a class
function [`ICT_MOVE_W-1:0] move_form;
    input [`ICT_CLASS_W-1:0] cls;
    begin
        case (cls)
            `ICT_CLASS_MOVE_R2A: begin
                move_form = `ICT_MOVE_R2A;
            end
            `ICT_CLASS_MOVE_A2R: begin
                move_form = `ICT_MOVE_A2R;
            end
            `ICT_CLASS_MOVE_IMM: begin
                move_form = `ICT_MOVE_IMM;
            end
            default: begin
                move_form = `ICT_MOVE_NONE;
            end
        endcase
    end
endfunction

assign cycle_end = (phase == `ICT_PHASE_LAST);

// sampled only when cycle_end is high
assign wants_two = needs_two(instr_class_in, writes_program_counter_low_byte_in,
    skip_taken_in);

always @* begin
    if (cycle_end) begin
        next_phase = `ICT_PHASE_FIRST;
    end else begin
        next_phase = phase + {{(`ICT_PHASE_W-1){1'b0}}, 1'b1};
    end
end

always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
        phase <= `ICT_PHASE_FIRST;
    end else begin
        phase <= next_phase;
    end
end

always @* begin
    next_state = state;
    next_extra = 1'b0;
    case (state)
        ST_FIRST: begin
            if (cycle_end && wants_two) begin
                next_state = ST_SECOND;
                next_extra = 1'b1;
            end
        end
        ST_SECOND: begin
            if (cycle_end) begin
                next_state = ST_FIRST;
            end else begin
                next_extra = 1'b1;
            end
        end
        default: begin
            next_state = ST_FIRST;
        end
    endcase
end

// next values of the registered outputs
always @* begin
    next_instr_cycle = cycle_end;
    // instruction done at end of its final cycle
    next_fetch_ready = cycle_end & (next_state == ST_FIRST);
    next_move = move_form(instr_class_in);
end

always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
        state <= ST_FIRST;
    end else begin
        state <= next_state;
    end
end

// boundary pulse
always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
        instr_cycle_out <= 1'b0;
    end else begin
        instr_cycle_out <= next_instr_cycle;
    end
end

// phase seen one clock late
always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
        phase_out <= `ICT_PHASE_FIRST;
    end else begin
        phase_out <= phase;
    end
end

always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
        fetch_ready_out <= 1'b0;
    end else begin
        fetch_ready_out <= next_fetch_ready;
    end
end

always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
        extra_cycle_out <= 1'b0;
    end else begin
        extra_cycle_out <= next_extra;
    end
end

always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
        data_move_instruction_out <= `ICT_MOVE_NONE;
    end else begin
        data_move_instruction_out <= next_move;
    end
end

always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
        pulldown_option_port_line_en_out <= 1'b0;
    end else begin
        pulldown_option_port_line_en_out <= pulldown_option_cfg_in;
    end
end

endmodule // ict_timing

// >>> verif/ict_timing_properties.sv
// assertions on ict_timing ports; bound after the module
`timescale 1ns/10ps
module ict_timing_properties (
    input wire core_clk_in, rst_in, writes_program_counter_low_byte_in, skip_taken_in,
    input wire pulldown_option_cfg_in, instr_cycle_out, fetch_ready_out, extra_cycle_out,
    input wire pulldown_option_port_line_en_out, input wire [3:0] instr_class_in,
    input wire [1:0] phase_out, data_move_instruction_out);
    wire b = instr_cycle_out, x = extra_cycle_out, r = fetch_ready_out;
    wire [3:0] c = instr_class_in;
    reg two;
    always @(posedge core_clk_in) begin
        two <= c && c < 4'h6 || writes_program_counter_low_byte_in || c == 4'h6 && skip_taken_in;
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_ext4; x [*4]; endsequence
    a_cycle_period: assert property (b |=> !b [*3] ##1 b) else $error("spacing");
    a_phase_step: assert property (phase_out != 2'h0 |=>
        phase_out == $past(phase_out) + 2'h1) else $error("phase");
    a_reset_phase: assert property ($fell(rst_in) |-> phase_out == 2'h0 ##4 b)
        else $error("start");
    a_ready_boundary: assert property (r |-> b) else $error("ready");
    a_two_extra:
        assert property (b && !$past(x) && two |-> !r ##0 s_ext4 ##1 r) else $error("two");
    a_one_ready: assert property (b && !$past(x) && !two |-> r && !x)
        else $error("one");
    a_move_form: assert property (1 |=> data_move_instruction_out ==
        ($past(c) > 4'h6 && $past(c) < 4'hA ? $past(c[1:0]) + 2'h2 : 2'h0))
        else $error("move");
    a_option_copy: assert property (1 |=> pulldown_option_port_line_en_out ==
        $past(pulldown_option_cfg_in)) else $error("option");
endmodule // ict_timing_properties
bind ict_timing ict_timing_properties i_props (.*);

// >>> verif/tb_ict_timing.sv
// bench for ict_timing, inputs driven at the falling clock edge
`timescale 1ns/10ps
module tb_ict_timing;
    reg core_clk_in = 0, rst_in = 1, skip_taken_in = 0, pulldown_option_cfg_in = 1;
    reg writes_program_counter_low_byte_in = 0;
    reg [3:0] instr_class_in = 0;
    wire instr_cycle_out, fetch_ready_out, extra_cycle_out, pulldown_option_port_line_en_out;
    wire [1:0] phase_out, data_move_instruction_out;
    wire [4:0] o = {instr_cycle_out, extra_cycle_out, fetch_ready_out, data_move_instruction_out};
    int errors = 0, check_count = 0;
    ict_timing i_dut (.*);
    initial forever #25 core_clk_in = ~core_clk_in;
    task complete_run;
        if (errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [7:0] got, exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %0h %0h", $time, got, exp);
        end
    endtask
    // one instruction; boundary pulse rises at the fourth rising edge after it is presented and is checked at the next falling edge
    task issue(input logic [3:0] c, input logic p, s);
        logic t;
        t = c && c < 4'h6 || p || c == 4'h6 && s;
        {instr_class_in, writes_program_counter_low_byte_in, skip_taken_in} = {c, p, s};
        repeat (4) @(negedge core_clk_in);
        chk(o, {1'h1, t, !t, c > 4'h6 ? c[1:0] + 2'h2 : 2'h0});
        if (t) begin
            repeat (4) @(negedge core_clk_in);
            chk(o[4:2], 3'h5);
        end
    endtask
    initial begin
        repeat (3) @(negedge core_clk_in);
        rst_in = 0;
        for (int c = 0; c < 10; c++) issue(c[3:0], 0, 0);
        issue(0, 1, 0);
        issue(2, 1, 0);
        issue(6, 0, 1);
        issue(6, 0, 0);
        chk(pulldown_option_port_line_en_out, 1);
        pulldown_option_cfg_in = 0;
        @(negedge core_clk_in);
        rst_in = 1;
        @(negedge core_clk_in);
        chk({phase_out, pulldown_option_port_line_en_out, o}, 0);
        rst_in = 0;
        issue(0, 0, 0);
        chk(pulldown_option_port_line_en_out, 0);
        complete_run;
    end
endmodule // tb_ict_timing
